// ### verilog/ledc_ctrl.sv
// control logic of a six-output led driver: pin duty, grouping,
// logarithmic brightness and charge pump gain selection
// assumes writes arrive decoded from the serial engine on mclk;
// pin and comparator inputs are asynchronous

`timescale 1ns/1ps

module ledc_ctrl #(
    parameter int NUM_OUT = 6
) (
    input  wire logic                              mclk,
    input  wire logic                              srst,
    input  wire logic                              en_pwm_pin,
    input  wire logic                              cath_low,
    input  wire logic                              cath_high,
    input  wire ledc_pkg::ledc_wr_t                wr,
    output logic                                   serial_en_q,
    output logic                                   dim_mode_q,
    output logic [NUM_OUT-1:0]                     led_on_q,
    output logic [NUM_OUT-1:0][ledc_pkg::CUR_W-1:0] led_cur_q,
    output logic                                   cp_15x_q
);

    localparam int NCH = NUM_OUT - 1;

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (NUM_OUT < 3 || NUM_OUT > 7) begin : g_bad
        $error("ledc_ctrl: NUM_OUT must lie in 3..7");
    end

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] lvl_q;
    logic [2:0] lvl_d;

    // a level moves once the second and third stages agree
    always_comb begin
        lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end

    // only the second stage reads the first; srst alone clears them
    always_ff @(posedge mclk) begin
        if (srst) begin
            s1_q  <= 3'h0;
            s2_q  <= 3'h0;
            s3_q  <= 3'h0;
            lvl_q <= 3'h0;
        end else begin
            s1_q  <= {cath_high, cath_low, en_pwm_pin};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    logic pin_q;
    logic low_q;
    logic high_q;
    assign pin_q  = lvl_q[0];
    assign low_q  = lvl_q[1];
    assign high_q = lvl_q[2];

    // ------------------------------------------------------------------
    // internal reset
    // ------------------------------------------------------------------
    logic gp_mode;
    logic rst_int;
    // a low pin only resets while it serves as enable
    assign rst_int = srst | (~gp_mode & ~pin_q);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [7:0]            gp_q;
    logic [7:0]            gp_d;
    logic [7:0]            grp_q;
    logic [7:0]            grp_d;
    logic [ledc_pkg::LVL_W-1:0] bri_q [NCH];
    logic [ledc_pkg::LVL_W-1:0] bri_d [NCH];
    assign gp_mode = gp_q[ledc_pkg::GP_MODE_BIT];

    // register writes, accepted regardless of led state
    always_comb begin
        gp_d  = gp_q;
        grp_d = grp_q;
        for (int c = 0; c < NCH; c++) begin
            bri_d[c] = bri_q[c];
        end
        if (wr.valid) begin
            case (wr.sel)
                ledc_pkg::SEL_GP:    gp_d  = wr.data;
                ledc_pkg::SEL_GROUP: grp_d = wr.data;
                ledc_pkg::SEL_BRIGHT: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (int'(wr.chan) == c) begin
                            bri_d[c] = wr.data[ledc_pkg::LVL_W-1:0];
                        end
                    end
                end
                default: gp_d = gp_q;
            endcase
        end
    end

    // registers return to defaults under the internal reset
    always_ff @(posedge mclk) begin
        if (rst_int) begin
            gp_q  <= ledc_pkg::GP_RST;
            grp_q <= ledc_pkg::GROUP_RST;
            for (int c = 0; c < NCH; c++) begin
                bri_q[c] <= ledc_pkg::BRIGHT_RST;
            end
        end else begin
            gp_q  <= gp_d;
            grp_q <= grp_d;
            for (int c = 0; c < NCH; c++) begin
                bri_q[c] <= bri_d[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // brightness decode
    // ------------------------------------------------------------------
    // mantissa 8..15 shifted by code[5:3] octaves: equal steps within an octave
    function automatic logic [ledc_pkg::CUR_W-1:0] lvl2cur(
        input logic [ledc_pkg::LVL_W-1:0] code
    );
        logic [ledc_pkg::CUR_W-1:0] m;
        m = {7'h00, 1'b1, code[2:0]};
        return m << code[5:3];
    endfunction

    // ------------------------------------------------------------------
    // led outputs
    // ------------------------------------------------------------------
    logic [NUM_OUT-1:0]                      on_d;
    logic [NUM_OUT-1:0][ledc_pkg::CUR_W-1:0] cur_d;
    logic [NUM_OUT-1:0]                      in_main;

    // grouping, enables and main group gating by the dimming pin
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            in_main[i] = (i < ledc_pkg::MAIN_BASE) || grp_q[i];
            if (in_main[i]) begin
                on_d[i]  = gp_q[ledc_pkg::GP_MAIN_EN];
                cur_d[i] = lvl2cur(bri_q[0]);
            end else begin
                on_d[i]  = gp_q[i-1];
                cur_d[i] = lvl2cur(bri_q[i-1]);
            end
            // current follows pin: average is level times duty
            if (in_main[i] && gp_mode && !pin_q) begin
                on_d[i] = 1'b0;
            end
            if (!on_d[i]) begin
                cur_d[i] = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            led_on_q    <= '0;
            led_cur_q   <= '0;
            serial_en_q <= 1'b0;
            dim_mode_q  <= 1'b0;
        end else begin
            led_on_q    <= on_d;
            led_cur_q   <= cur_d;
            serial_en_q <= 1'b1;
            dim_mode_q  <= gp_mode;
        end
    end

    // ------------------------------------------------------------------
    // charge pump gain
    // ------------------------------------------------------------------
    ledc_pkg::ledc_cp_t cp_q;
    ledc_pkg::ledc_cp_t cp_d;

    always_comb begin
        case (cp_q)
            ledc_pkg::CP_1X: begin
                cp_d = (low_q && |led_on_q) ? ledc_pkg::CP_15X
                                            : ledc_pkg::CP_1X;
            end
            ledc_pkg::CP_15X: begin
                cp_d = (high_q && !low_q) ? ledc_pkg::CP_1X
                                          : ledc_pkg::CP_15X;
            end
            default: cp_d = ledc_pkg::CP_1X;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst_int) begin
            cp_q     <= ledc_pkg::CP_1X;
            cp_15x_q <= 1'b0;
        end else begin
            cp_q     <= cp_d;
            cp_15x_q <= (cp_d == ledc_pkg::CP_15X);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_enable_runs;
        @(posedge mclk) disable iff (srst)
        (!gp_mode && pin_q) |=> serial_en_q;
    endproperty
    a_enable_runs: assert property (p_enable_runs)
        else $error("serial port not enabled with pin high");
    property p_low_pin_reset;
        @(posedge mclk) disable iff (srst)
        (!gp_mode && !pin_q) |=> (!serial_en_q && led_on_q == '0 && !cp_15x_q);
    endproperty
    a_low_pin_reset: assert property (p_low_pin_reset)
        else $error("device active while enable pin low");
    property p_mode_set;
        @(posedge mclk) disable iff (rst_int)
        (wr.valid && wr.sel == ledc_pkg::SEL_GP
         && wr.data[ledc_pkg::GP_MODE_BIT]) |=> ##1 dim_mode_q;
    endproperty
    a_mode_set: assert property (p_mode_set)
        else $error("mode bit write did not enter dimming duty");
    property p_defaults;
        @(posedge mclk) disable iff (srst)
        (!gp_mode && !pin_q) |=> (gp_q == ledc_pkg::GP_RST
                                  && grp_q == ledc_pkg::GROUP_RST);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("registers not at default after enable low");
    property p_dim_gate;
        @(posedge mclk) disable iff (srst)
        (gp_mode && !pin_q) |=> (led_on_q[1:0] == 2'h0);
    endproperty
    a_dim_gate: assert property (p_dim_gate)
        else $error("main group on while dimming pin low");
    // a write that hands back enable duty may reset the outputs on the second edge after it
    property p_dim_no_reset;
        @(posedge mclk) disable iff (srst)
        (gp_mode && !pin_q && !(wr.valid && wr.sel == ledc_pkg::SEL_GP
         && !wr.data[ledc_pkg::GP_MODE_BIT]))
        |=> (serial_en_q && dim_mode_q)[*2];
    endproperty
    a_dim_no_reset: assert property (p_dim_no_reset)
        else $error("low dimming pin reset the device");
    property p_pump_up;
        @(posedge mclk) disable iff (rst_int)
        (cp_q == ledc_pkg::CP_1X && low_q && |led_on_q) |=> cp_15x_q;
    endproperty
    a_pump_up: assert property (p_pump_up)
        else $error("pump stayed in 1x with low cathode");
    property p_pump_down;
        @(posedge mclk) disable iff (rst_int)
        (cp_q == ledc_pkg::CP_15X && high_q && !low_q) |=> !cp_15x_q;
    endproperty
    a_pump_down: assert property (p_pump_down)
        else $error("pump stayed in 1.5x with high cathode");
    property p_log_level;
        @(posedge mclk) disable iff (rst_int)
        led_on_q[0] |-> led_cur_q[0] == lvl2cur($past(bri_q[0]));
    endproperty
    a_log_level: assert property (p_log_level)
        else $error("main group current does not match level code");
    property p_default_group;
        @(posedge mclk) disable iff (rst_int)
        (grp_q == 8'h00 && gp_q[1]) |=> led_on_q[2];
    endproperty
    a_default_group: assert property (p_default_group)
        else $error("single channel not driven by its own enable");

endmodule

// ### verilog/ledc_pkg.sv
// package of shared constants and types for the led driver control block
// assumes a single 125 MHz clock and a write port fed by a serial engine

package ledc_pkg;

    // ------------------------------------------------------------------
    // widths and structure
    // ------------------------------------------------------------------
    localparam int          LVL_W       = 6;     // 64 brightness codes
    localparam int          CUR_W       = 11;    // relative current word
    localparam int          MAIN_BASE   = 2;     // fixed main group outputs
    localparam int          SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // write port selectors and field positions
    // ------------------------------------------------------------------
    localparam logic [1:0]  SEL_GP      = 2'h0;  // general purpose reg
    localparam logic [1:0]  SEL_GROUP   = 2'h1;  // main group membership
    localparam logic [1:0]  SEL_BRIGHT  = 2'h2;  // per-channel brightness
    localparam int          GP_MODE_BIT = 7;     // pin as dimming input
    localparam int          GP_MAIN_EN  = 0;     // main group enable

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]  GP_RST      = 8'h00;
    localparam logic [7:0]  GROUP_RST   = 8'h00;
    localparam logic [5:0]  BRIGHT_RST  = 6'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;   // one-cycle write strobe
        logic [1:0] sel;     // which register
        logic [2:0] chan;    // brightness channel
        logic [7:0] data;    // write data
    } ledc_wr_t;

    typedef enum logic [1:0] {
        CP_1X  = 2'b01,
        CP_15X = 2'b10
    } ledc_cp_t;

endpackage

// ### tb/ledc_host_model.sv
// host model: writes registers and drives the enable/dimming pin
// assumes its tasks are called just after a rising edge of mclk

`timescale 1ns/1ps

module ledc_host_model (
    input  wire logic         mclk,
    output logic              en_pwm_pin,
    output ledc_pkg::ledc_wr_t wr
);
    // ------------------------------------------------------------------
    // idle state: pin high keeps the device enabled
    // ------------------------------------------------------------------
    initial begin
        en_pwm_pin = 1'b1;
        wr = '0;
    end

    // one-cycle strobe, then released fields go to their inverse
    task automatic wr_reg(input logic [1:0] sel, input logic [2:0] chan,
                          input logic [7:0] data);
        wr <= '{1'b1, sel, chan, data};
        @(posedge mclk);
        wr <= '{1'b0, ~sel, ~chan, ~data};
        @(posedge mclk);
    endtask

    // pin level held from the next edge on
    task automatic set_pin(input logic v);
        en_pwm_pin <= v;
        @(posedge mclk);
    endtask

    // dimming waveform; period kept at or above 6250 cycles
    task automatic pwm(input int period, input int high, input int n);
        repeat (n) begin
            en_pwm_pin <= 1'b1;
            repeat (high) @(posedge mclk);
            en_pwm_pin <= 1'b0;
            repeat (period - high) @(posedge mclk);
        end
        en_pwm_pin <= 1'b1;
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench of the led driver control block
// assumes the host model drives pin and writes; comparators from here

`timescale 1ns/1ps

module tb;
    typedef struct packed {
        logic [1:0]  sel;
        logic [2:0]  chan;
        logic [7:0]  data;
        logic [5:0]  on;
        logic [2:0]  idx;
        logic [10:0] cur;
    } ledc_row_t;

    logic                                  mclk;
    logic                                  srst;
    logic                                  cath_low;
    logic                                  cath_high;
    logic                                  en_pwm_pin;
    ledc_pkg::ledc_wr_t                    wr;
    logic                                  serial_en_q;
    logic                                  dim_mode_q;
    logic                                  cp_15x_q;
    logic [5:0]                            led_on_q;
    logic [5:0][ledc_pkg::CUR_W-1:0]       led_cur_q;
    int                                    num_errors = 0;
    int                                    n_tests = 0;
    int                                    cnt;
    ledc_row_t                             rows [9];

    // ------------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ledc_ctrl DUT (.mclk(mclk), .srst(srst), .en_pwm_pin(en_pwm_pin),
        .cath_low(cath_low), .cath_high(cath_high), .wr(wr),
        .serial_en_q(serial_en_q), .dim_mode_q(dim_mode_q),
        .led_on_q(led_on_q), .led_cur_q(led_cur_q), .cp_15x_q(cp_15x_q));

    ledc_host_model HOST (.mclk(mclk), .en_pwm_pin(en_pwm_pin), .wr(wr));

    // relative current of a brightness code
    function automatic logic [10:0] lvl(input logic [5:0] c);
        return ({8'h00, c[2:0]} + 11'h008) << c[5:3];
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog sized well above the 13k cycles the tests need
    initial begin
        #(8 * 40000);
        num_errors++;
        test_done();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        cath_low = 1'b0;
        cath_high = 1'b0;
        rows[0] = '{2'h0, 3'h0, 8'h01, 6'h03, 3'h0, lvl(6'h00)};
        rows[1] = '{2'h2, 3'h0, 8'h3F, 6'h03, 3'h1, lvl(6'h3F)};
        rows[2] = '{2'h2, 3'h1, 8'h09, 6'h03, 3'h2, 11'h000};
        rows[3] = '{2'h0, 3'h0, 8'h03, 6'h07, 3'h2, lvl(6'h09)};
        rows[4] = '{2'h1, 3'h0, 8'h3C, 6'h3F, 3'h5, lvl(6'h3F)};
        rows[5] = '{2'h1, 3'h0, 8'h00, 6'h07, 3'h5, 11'h000};
        rows[6] = '{2'h2, 3'h4, 8'h12, 6'h07, 3'h5, 11'h000};
        rows[7] = '{2'h0, 3'h0, 8'h1F, 6'h3F, 3'h5, lvl(6'h12)};
        rows[8] = '{2'h3, 3'h0, 8'h00, 6'h3F, 3'h5, lvl(6'h12)};
        repeat (4) @(posedge mclk);
        chk("serial_en", 0, serial_en_q);
        chk("led_on", 0, led_on_q);
        srst <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("serial_en", 1, serial_en_q);
        chk("dim_mode", 0, dim_mode_q);
        $display("test reset done");
        foreach (rows[i]) begin
            HOST.wr_reg(rows[i].sel, rows[i].chan, rows[i].data);
            repeat (2) @(posedge mclk);
            chk("led_on", rows[i].on, led_on_q);
            chk("led_cur", rows[i].cur, led_cur_q[rows[i].idx]);
        end
        $display("test table done");
        HOST.wr_reg(2'h0, 3'h0, 8'h81);
        repeat (2) @(posedge mclk);
        chk("dim_mode", 1, dim_mode_q);
        chk("led_on", 6'h03, led_on_q);
        HOST.set_pin(1'b0);
        repeat (10) @(posedge mclk);
        chk("led_on", 0, led_on_q);
        chk("serial_en", 1, serial_en_q);
        chk("dim_mode", 1, dim_mode_q);
        HOST.wr_reg(2'h2, 3'h0, 8'h00);
        HOST.set_pin(1'b1);
        repeat (10) @(posedge mclk);
        chk("led_on", 6'h03, led_on_q);
        chk("led_cur", lvl(6'h00), led_cur_q[0]);
        fork
            HOST.pwm(6400, 1600, 2);
            begin
                cnt = 0;
                repeat (12800) begin
                    @(posedge mclk);
                    if (led_on_q[0] === 1'b1) cnt++;
                end
            end
        join
        chk("duty", 1, (cnt >= 3192 && cnt <= 3208));
        $display("test dimming done");
        // let the synchronised pin settle high before giving back enable
        repeat (8) @(posedge mclk);
        HOST.wr_reg(2'h0, 3'h0, 8'h01);
        repeat (2) @(posedge mclk);
        chk("dim_mode", 0, dim_mode_q);
        chk("serial_en", 1, serial_en_q);
        chk("led_on", 6'h03, led_on_q);
        HOST.set_pin(1'b0);
        repeat (10) @(posedge mclk);
        chk("serial_en", 0, serial_en_q);
        chk("led_on", 0, led_on_q);
        HOST.wr_reg(2'h0, 3'h0, 8'h81);
        HOST.set_pin(1'b1);
        repeat (10) @(posedge mclk);
        chk("serial_en", 1, serial_en_q);
        chk("led_on", 0, led_on_q);
        chk("dim_mode", 0, dim_mode_q);
        $display("test enable done");
        HOST.wr_reg(2'h0, 3'h0, 8'h01);
        repeat (4) @(posedge mclk);
        chk("cp_15x", 0, cp_15x_q);
        cath_low <= 1'b1;
        repeat (10) @(posedge mclk);
        chk("cp_15x", 1, cp_15x_q);
        cath_low <= 1'b0;
        cath_high <= 1'b1;
        repeat (10) @(posedge mclk);
        chk("cp_15x", 0, cp_15x_q);
        $display("test pump done");
        test_done();
    end
endmodule
